// >>> hw/i2c_control_low_bits.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module i2c_control_low_bits (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N_O,
  output logic SMBUS_LEVEL_O,
  output logic IRQ_O
);

  i2c_ctl_pkg::i2c_state_type q;
  i2c_ctl_pkg::i2c_state_type d;

  logic [i2c_ctl_pkg::EV_W-1:0] ev;
  logic [i2c_ctl_pkg::EV_W-1:0] clr;
  logic sda_new;
  logic scl_new;
  logic sda_rise;
  logic sda_fall;
  logic scl_rise;
  logic scl_fall;
  logic tick;
  logic ctrl_mode;
  logic tgt_mode;
  logic ack_bit;
  logic [31:0] rd;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == i2c_ctl_pkg::CTRL_OFFSET) || (addr == i2c_ctl_pkg::CONFIG_OFFSET) ||
                (addr == i2c_ctl_pkg::TXDATA_OFFSET) || (addr == i2c_ctl_pkg::RXDATA_OFFSET) ||
                (addr == i2c_ctl_pkg::STATUS_OFFSET) || (addr == i2c_ctl_pkg::CLEAR_OFFSET) ||
                (addr == i2c_ctl_pkg::IRQ_EN_OFFSET) || (addr == i2c_ctl_pkg::STATE_OFFSET);
  endfunction

  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    rd = '0;
    ack_bit = 1'b0;
    ctrl_mode = q.cfg[i2c_ctl_pkg::CFG_ENABLE] & ~q.cfg[i2c_ctl_pkg::CFG_TARGET];
    tgt_mode = q.cfg[i2c_ctl_pkg::CFG_ENABLE] & q.cfg[i2c_ctl_pkg::CFG_TARGET];

    // Pin filter: a level counts once stages two and three agree
    d.sda_s = {q.sda_s[1:0], SDA_I};
    d.scl_s = {q.scl_s[1:0], SCL_I};
    sda_new = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
    scl_new = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
    d.sda_f = sda_new;
    d.scl_f = scl_new;
    sda_rise = sda_new & ~q.sda_f;
    sda_fall = ~sda_new & q.sda_f;
    scl_rise = scl_new & ~q.scl_f;
    scl_fall = ~scl_new & q.scl_f;

    tick = (q.div == i2c_ctl_pkg::QUARTER_CYC - 9'h001);
    d.div = tick ? 9'h000 : q.div + 9'h001;

    // Controller engine, one quarter bit per tick
    if (!ctrl_mode) begin
      d.m_state = i2c_ctl_pkg::M_IDLE;
      d.m_phase = 2'h0;
      d.m_scl_low = 1'b0;
      d.m_sda_low = 1'b0;
    end else if (tick) begin
      d.m_phase = q.m_phase + 2'h1;
      unique case (q.m_state)
        i2c_ctl_pkg::M_IDLE: begin
          d.m_phase = 2'h0;
          d.m_bit = 4'h0;
          if (q.ctl[i2c_ctl_pkg::CTL_START]) begin
            d.m_state = i2c_ctl_pkg::M_START;
          end else if (q.ctl[i2c_ctl_pkg::CTL_RESTART]) begin
            d.m_state = i2c_ctl_pkg::M_RESTART;
          end else if (q.ctl[i2c_ctl_pkg::CTL_STOP]) begin
            d.m_state = i2c_ctl_pkg::M_STOP;
          end else if (q.ctl[i2c_ctl_pkg::CTL_RECEIVE]) begin
            d.m_state = i2c_ctl_pkg::M_RX;
            d.m_shift = 8'h00;
          end else if (q.ctl[i2c_ctl_pkg::CTL_ACKGO]) begin
            d.m_state = i2c_ctl_pkg::M_ACK;
          end else if (q.tx_pend) begin
            d.m_state = i2c_ctl_pkg::M_TX;
            d.m_shift = q.tx_data;
            d.tx_pend = 1'b0;
          end
        end
        i2c_ctl_pkg::M_START: begin
          unique case (q.m_phase)
            2'h0: begin
              d.m_sda_low = 1'b0;
              d.m_scl_low = 1'b0;
            end
            2'h1: d.m_sda_low = 1'b1;
            default: begin
              d.m_scl_low = 1'b1;
              d.m_state = i2c_ctl_pkg::M_IDLE;
              d.ctl[i2c_ctl_pkg::CTL_START] = 1'b0;
              ev[i2c_ctl_pkg::EV_SEQ_DONE] = 1'b1;
            end
          endcase
        end
        i2c_ctl_pkg::M_RESTART: begin
          unique case (q.m_phase)
            2'h0: d.m_sda_low = 1'b0;
            2'h1: d.m_scl_low = 1'b0;
            2'h2: d.m_sda_low = 1'b1;
            default: begin
              d.m_scl_low = 1'b1;
              d.m_state = i2c_ctl_pkg::M_IDLE;
              d.ctl[i2c_ctl_pkg::CTL_RESTART] = 1'b0;
              ev[i2c_ctl_pkg::EV_SEQ_DONE] = 1'b1;
            end
          endcase
        end
        i2c_ctl_pkg::M_STOP: begin
          unique case (q.m_phase)
            2'h0: d.m_sda_low = 1'b1;
            2'h1: d.m_scl_low = 1'b0;
            default: begin
              d.m_sda_low = 1'b0;
              d.m_state = i2c_ctl_pkg::M_IDLE;
              d.ctl[i2c_ctl_pkg::CTL_STOP] = 1'b0;
              ev[i2c_ctl_pkg::EV_SEQ_DONE] = 1'b1;
            end
          endcase
        end
        default: begin
          // Data, receive and acknowledge bit slots share one bit cycle
          unique case (q.m_phase)
            2'h0: begin
              d.m_scl_low = 1'b1;
              if (q.m_state == i2c_ctl_pkg::M_TX) begin
                d.m_sda_low = (q.m_bit < i2c_ctl_pkg::BYTE_BITS) & ~q.m_shift[7];
              end else if (q.m_state == i2c_ctl_pkg::M_ACK) begin
                d.m_sda_low = ~q.ctl[i2c_ctl_pkg::CTL_ACKVAL];
              end else begin
                d.m_sda_low = 1'b0;
              end
            end
            2'h1: d.m_scl_low = 1'b0;
            2'h2: begin
              // A target holding the clock low stalls the sample point
              if (!q.scl_f) begin
                d.m_phase = 2'h2;
              end else if (q.m_state == i2c_ctl_pkg::M_RX) begin
                d.m_shift = {q.m_shift[6:0], q.sda_f};
              end else if (q.m_state == i2c_ctl_pkg::M_TX &&
                           q.m_bit == i2c_ctl_pkg::BYTE_BITS) begin
                d.ack_rx = q.sda_f;
              end
            end
            default: begin
              d.m_scl_low = 1'b1;
              d.m_bit = q.m_bit + 4'h1;
              if (q.m_state == i2c_ctl_pkg::M_TX) begin
                d.m_shift = {q.m_shift[6:0], 1'b0};
                if (q.m_bit == i2c_ctl_pkg::BYTE_BITS) begin
                  d.m_state = i2c_ctl_pkg::M_IDLE;
                  d.m_sda_low = 1'b0;
                  ev[i2c_ctl_pkg::EV_TX_DONE] = 1'b1;
                  ev[i2c_ctl_pkg::EV_NACK] = q.ack_rx;
                end
              end else if (q.m_state == i2c_ctl_pkg::M_RX) begin
                if (q.m_bit == i2c_ctl_pkg::BYTE_BITS - 4'h1) begin
                  d.m_state = i2c_ctl_pkg::M_IDLE;
                  d.rx_data = q.m_shift;
                  d.ctl[i2c_ctl_pkg::CTL_RECEIVE] = 1'b0;
                  ev[i2c_ctl_pkg::EV_RX_DONE] = 1'b1;
                end
              end else begin
                d.m_state = i2c_ctl_pkg::M_IDLE;
                d.m_sda_low = 1'b0;
                d.ctl[i2c_ctl_pkg::CTL_ACKGO] = 1'b0;
                ev[i2c_ctl_pkg::EV_SEQ_DONE] = 1'b1;
              end
            end
          endcase
        end
      endcase
    end

    // Target engine, paced by edges of the sampled bus clock
    if (!tgt_mode) begin
      d.t_state = i2c_ctl_pkg::T_IDLE;
      d.t_sda_low = 1'b0;
      d.t_scl_low = 1'b0;
    end else if (q.scl_f && scl_new && sda_fall) begin
      d.t_state = i2c_ctl_pkg::T_ADDR;
      d.t_bit = 4'h0;
      d.t_sda_low = 1'b0;
    end else if (q.scl_f && scl_new && sda_rise) begin
      d.t_state = i2c_ctl_pkg::T_IDLE;
      d.t_sda_low = 1'b0;
      d.t_scl_low = 1'b0;
      ev[i2c_ctl_pkg::EV_STOP_SEEN] = 1'b1;
    end else if (scl_rise) begin
      if (q.t_state == i2c_ctl_pkg::T_ADDR || q.t_state == i2c_ctl_pkg::T_RX) begin
        d.t_shift = {q.t_shift[6:0], q.sda_f};
        d.t_bit = q.t_bit + 4'h1;
      end else if (q.t_state == i2c_ctl_pkg::T_TXACK) begin
        d.t_nack = q.sda_f;
      end
    end else if (scl_fall) begin
      unique case (q.t_state)
        i2c_ctl_pkg::T_ADDR: begin
          if (q.t_bit == i2c_ctl_pkg::BYTE_BITS) begin
            ack_bit = q.cfg[i2c_ctl_pkg::CFG_AHOLD] & q.ctl[i2c_ctl_pkg::CTL_ACKVAL];
            if (q.t_shift[7:1] == q.cfg[i2c_ctl_pkg::CFG_ADDR_LSB +: 7]) begin
              ev[i2c_ctl_pkg::EV_ADDR_MATCH] = 1'b1;
              d.t_read = q.t_shift[0];
              d.t_nack = ack_bit;
              d.t_sda_low = ~ack_bit;
              d.t_state = i2c_ctl_pkg::T_ACK;
            end else if (q.t_shift == i2c_ctl_pkg::GEN_CALL_ADDR &&
                         q.ctl[i2c_ctl_pkg::CTL_GCALL]) begin
              ev[i2c_ctl_pkg::EV_GEN_CALL] = 1'b1;
              d.t_read = 1'b0;
              d.t_nack = ack_bit;
              d.t_sda_low = ~ack_bit;
              d.t_state = i2c_ctl_pkg::T_ACK;
            end else begin
              d.t_state = i2c_ctl_pkg::T_IDLE;
            end
          end
        end
        i2c_ctl_pkg::T_RX: begin
          if (q.t_bit == i2c_ctl_pkg::BYTE_BITS) begin
            ack_bit = q.cfg[i2c_ctl_pkg::CFG_DHOLD] & q.ctl[i2c_ctl_pkg::CTL_ACKVAL];
            d.rx_data = q.t_shift;
            ev[i2c_ctl_pkg::EV_RX_DONE] = 1'b1;
            d.t_nack = ack_bit;
            d.t_sda_low = ~ack_bit;
            d.t_state = i2c_ctl_pkg::T_ACK;
            // End of reception: only the stretching variant of release clears
            if (q.ctl[i2c_ctl_pkg::CTL_STRETCH]) begin
              d.cfg[i2c_ctl_pkg::CFG_RELEASE] = 1'b0;
              d.t_scl_low = 1'b1;
            end
          end
        end
        i2c_ctl_pkg::T_ACK, i2c_ctl_pkg::T_TXACK: begin
          d.t_sda_low = 1'b0;
          d.t_bit = 4'h0;
          if (q.t_nack) begin
            d.t_state = i2c_ctl_pkg::T_IDLE;
          end else if (q.t_read) begin
            // Start of target transmission clears release in every variant
            d.cfg[i2c_ctl_pkg::CFG_RELEASE] = 1'b0;
            d.t_scl_low = q.ctl[i2c_ctl_pkg::CTL_STRETCH];
            d.t_shift = q.tx_data;
            d.t_sda_low = ~q.tx_data[7];
            d.t_state = i2c_ctl_pkg::T_TX;
          end else begin
            d.t_state = i2c_ctl_pkg::T_RX;
          end
        end
        i2c_ctl_pkg::T_TX: begin
          d.t_bit = q.t_bit + 4'h1;
          d.t_shift = {q.t_shift[6:0], 1'b0};
          d.t_sda_low = ~q.t_shift[6];
          if (q.t_bit == i2c_ctl_pkg::BYTE_BITS - 4'h1) begin
            d.t_sda_low = 1'b0;
            d.t_state = i2c_ctl_pkg::T_TXACK;
            ev[i2c_ctl_pkg::EV_TX_DONE] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Holding stops once software releases, or stretching is turned off
    if (q.t_scl_low &&
        (q.cfg[i2c_ctl_pkg::CFG_RELEASE] || !q.ctl[i2c_ctl_pkg::CTL_STRETCH])) begin
      d.t_scl_low = 1'b0;
    end

    // APB slave: one wait state, writes land at the pready edge
    unique case (PADDR_I)
      i2c_ctl_pkg::CTRL_OFFSET: rd = {23'h000000, q.ctl};
      i2c_ctl_pkg::CONFIG_OFFSET: rd = {16'h0000, q.cfg};
      i2c_ctl_pkg::TXDATA_OFFSET: rd = {24'h000000, q.tx_data};
      i2c_ctl_pkg::RXDATA_OFFSET: rd = {24'h000000, q.rx_data};
      i2c_ctl_pkg::STATUS_OFFSET: rd = {25'h0000000, q.status};
      i2c_ctl_pkg::IRQ_EN_OFFSET: rd = {25'h0000000, q.irq_en};
      i2c_ctl_pkg::STATE_OFFSET: rd = {26'h0000000, q.m_state != i2c_ctl_pkg::M_IDLE,
                                       q.t_state != i2c_ctl_pkg::T_IDLE, q.t_read,
                                       q.ack_rx, q.scl_f, q.sda_f};
      default: rd = 32'h00000000;
    endcase
    if (PSEL_I && PENABLE_I && !q.apb_ack) begin
      d.apb_ack = 1'b1;
      d.prdata = PWRITE_I ? 32'h00000000 : rd;
      d.pslverr = ~is_mapped(PADDR_I);
    end else if (PSEL_I && PENABLE_I) begin
      d.apb_ack = 1'b0;
      d.pslverr = 1'b0;
      if (PWRITE_I && is_mapped(PADDR_I)) begin
        unique case (PADDR_I)
          i2c_ctl_pkg::CTRL_OFFSET: d.ctl = PWDATA_I[i2c_ctl_pkg::CTL_W-1:0];
          i2c_ctl_pkg::CONFIG_OFFSET: d.cfg = PWDATA_I[15:0] & i2c_ctl_pkg::CFG_WMASK;
          i2c_ctl_pkg::TXDATA_OFFSET: begin
            d.tx_data = PWDATA_I[7:0];
            d.tx_pend = ctrl_mode;
          end
          i2c_ctl_pkg::CLEAR_OFFSET: clr = PWDATA_I[i2c_ctl_pkg::EV_W-1:0];
          i2c_ctl_pkg::IRQ_EN_OFFSET: d.irq_en = PWDATA_I[i2c_ctl_pkg::EV_W-1:0];
          default: ;
        endcase
      end
    end else begin
      d.apb_ack = 1'b0;
      d.pslverr = 1'b0;
    end

    // New events win over a clear in the same cycle
    d.status = (q.status & ~clr) | ev;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      q <= '0;
      q.ctl <= i2c_ctl_pkg::CTL_RESET;
      q.cfg <= i2c_ctl_pkg::CFG_RESET;
      q.sda_s <= 3'h7;
      q.scl_s <= 3'h7;
      q.sda_f <= 1'b1;
      q.scl_f <= 1'b1;
      q.m_state <= i2c_ctl_pkg::M_IDLE;
      q.t_state <= i2c_ctl_pkg::T_IDLE;
    end else begin
      q <= d;
    end
  end

  assign PRDATA_O = q.prdata;
  assign PREADY_O = q.apb_ack;
  assign PSLVERR_O = q.pslverr & q.apb_ack;
  assign SDA_O = 1'b0;
  assign SCL_O = 1'b0;
  assign SDA_OE_N_O = ~(q.m_sda_low | q.t_sda_low);
  assign SCL_OE_N_O = ~(q.m_scl_low | q.t_scl_low);
  assign SMBUS_LEVEL_O = q.ctl[i2c_ctl_pkg::CTL_SMBUS];
  assign IRQ_O = |(q.status & q.irq_en);

endmodule
`default_nettype wire

// >>> hw/i2c_ctl_pkg.sv
// Overview of operation
// - Control bit 8 selects SMBus input thresholds for the serial pins.
// - Bit 7 lets the target accept the general call address and interrupt.
// - Bit 6 lets the target stretch the clock, with the clock release bit.
// - Controller receive sends bit 5 in the acknowledge; 1 is NACK, 0 ACK.
// - Target with address or data hold answers with bit 5 after each byte.
// - Bit 4 runs a controller acknowledge sequence; it reads 0 when idle.
// - Bit 3 receives one byte; hardware clears it after eight bits.
// - Bit 2 generates a Stop; it reads 0 when no Stop is running.
// - Bit 1 generates a repeated Start; it reads 0 when none is running.
// - Bit 0 generates a Start; it reads 0 when none is running.
// - First-note bit clears at target transmit start and target receive end.
// - Second-note bit clears only at target transmit start.
package i2c_ctl_pkg;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] TXDATA_OFFSET = 8'h08;
  localparam logic [7:0] RXDATA_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] CLEAR_OFFSET = 8'h14;
  localparam logic [7:0] IRQ_EN_OFFSET = 8'h18;
  localparam logic [7:0] STATE_OFFSET = 8'h1c;

  localparam int CTL_START = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP = 2;
  localparam int CTL_RECEIVE = 3;
  localparam int CTL_ACKGO = 4;
  localparam int CTL_ACKVAL = 5;
  localparam int CTL_STRETCH = 6;
  localparam int CTL_GCALL = 7;
  localparam int CTL_SMBUS = 8;
  localparam int CTL_W = 9;
  localparam logic [CTL_W-1:0] CTL_RESET = 9'h000;

  localparam int CFG_ENABLE = 0;
  localparam int CFG_TARGET = 1;
  localparam int CFG_RELEASE = 2;
  localparam int CFG_AHOLD = 3;
  localparam int CFG_DHOLD = 4;
  localparam int CFG_ADDR_LSB = 8;
  localparam logic [15:0] CFG_WMASK = 16'h7f1f;
  localparam logic [15:0] CFG_RESET = 16'h0004;

  localparam int EV_SEQ_DONE = 0;
  localparam int EV_RX_DONE = 1;
  localparam int EV_TX_DONE = 2;
  localparam int EV_NACK = 3;
  localparam int EV_ADDR_MATCH = 4;
  localparam int EV_GEN_CALL = 5;
  localparam int EV_STOP_SEEN = 6;
  localparam int EV_W = 7;

  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  localparam int CLK_PERIOD_NS = 8;
  localparam int QUARTER_BIT_NS = 2500;
  localparam logic [8:0] QUARTER_CYC =
    9'((QUARTER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_RESTART = 3'b010,
    M_STOP = 3'b011,
    M_TX = 3'b100,
    M_RX = 3'b101,
    M_ACK = 3'b110
  } ctrl_state_type;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_ADDR = 3'b001,
    T_ACK = 3'b010,
    T_RX = 3'b011,
    T_TX = 3'b100,
    T_TXACK = 3'b101
  } tgt_state_type;

  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [15:0] cfg;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] irq_en;
    logic apb_ack;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] sda_s;
    logic [2:0] scl_s;
    logic sda_f;
    logic scl_f;
    logic [8:0] div;
    ctrl_state_type m_state;
    logic [1:0] m_phase;
    logic [3:0] m_bit;
    logic [7:0] m_shift;
    logic m_scl_low;
    logic m_sda_low;
    logic tx_pend;
    logic ack_rx;
    tgt_state_type t_state;
    logic [3:0] t_bit;
    logic [7:0] t_shift;
    logic t_sda_low;
    logic t_scl_low;
    logic t_read;
    logic t_nack;
  } i2c_state_type;

endpackage

// >>> dv/i2c_control_low_bits_sva.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_control_low_bits_sva (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_N_O,
  input wire logic SMBUS_LEVEL_O,
  input wire logic IRQ_O
);
  logic take;
  logic wr_ctl;
  assign take = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_ctl = take && PWRITE_I && PADDR_I == i2c_ctl_pkg::CTRL_OFFSET;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  a_smbus_value: assert property (wr_ctl |=> SMBUS_LEVEL_O == $past(PWDATA_I[8]))
    else $error("smbus level does not follow control write");
  a_smbus_cause: assert property ($changed(SMBUS_LEVEL_O) |-> $past(wr_ctl) || $past(wr_ctl, 2))
    else $error("smbus level moved without a control write");
  a_open_drain: assert property (SDA_O == 1'b0 && SCL_O == 1'b0)
    else $error("pin drives a high level");
  a_sda_steady: assert property ($changed(SDA_OE_N_O) |=> $stable(SDA_OE_N_O) [*8])
    else $error("data line toggles too fast");
  a_scl_hold: assert property ($fell(SCL_OE_N_O) |=> !SCL_OE_N_O [*8])
    else $error("clock low phase too short");
  a_apb_wait: assert property ((PSEL_I && !PENABLE_I) ##1 (PSEL_I && PENABLE_I) |=> PREADY_O)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_err_mapping: assert property (take |-> PSLVERR_O ==
    (PADDR_I > i2c_ctl_pkg::STATE_OFFSET || PADDR_I[1:0] != 2'b00))
    else $error("error response does not match address");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_rdata_hold: assert property ($changed(PRDATA_O) |-> PREADY_O)
    else $error("read data moved outside an answer");
  a_reset_idle: assert property (disable iff (1'b0) !RESETN_I |-> SDA_OE_N_O && SCL_OE_N_O
    && !PREADY_O && !IRQ_O)
    else $error("outputs not idle in reset");
  c_ctl_write: cover property (wr_ctl);
  c_scl_held: cover property ($fell(SCL_OE_N_O));
  c_err: cover property (PSLVERR_O);
  c_irq: cover property ($rose(IRQ_O));
endmodule
bind i2c_control_low_bits i2c_control_low_bits_sva u_i2c_control_low_bits_sva (.SYS_CLK_I,
  .RESETN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O,
  .PSLVERR_O, .SDA_I, .SDA_O, .SDA_OE_N_O, .SCL_I, .SCL_O, .SCL_OE_N_O, .SMBUS_LEVEL_O, .IRQ_O);
`default_nettype wire

// >>> dv/i2c_peer.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_peer (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic send_i,
  input wire logic [7:0] data_i,
  input wire logic [15:0] stretch_i,
  output logic sda_pull_o,
  output logic scl_pull_o
);
  logic scl_q = 1'b1;
  logic rose_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [15:0] hold_q = 16'h0;
  // Shift only on falls after a rise, so data holds across each high phase
  always_ff @(posedge clk_i) begin
    scl_q <= scl_i;
    rose_q <= send_i && (rose_q || (scl_i && !scl_q));
    if (!send_i) cnt_q <= 4'h0;
    else if (!scl_i && scl_q && rose_q && cnt_q < 4'h8) cnt_q <= cnt_q + 4'h1;
    if (send_i && !scl_i && scl_q) hold_q <= stretch_i;
    else if (hold_q != 16'h0) hold_q <= hold_q - 16'h1;
  end
  assign sda_pull_o = send_i && cnt_q < 4'h8 && !data_i[3'(4'h7 - cnt_q)];
  // Slow mode: keeps the clock low past the controller's own low phase
  assign scl_pull_o = hold_q != 16'h0;
endmodule
`default_nettype wire

// >>> dv/i2c_control_low_bits_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module i2c_control_low_bits_test;
  localparam logic [7:0] CTRL = i2c_ctl_pkg::CTRL_OFFSET;
  localparam logic [7:0] CFG = i2c_ctl_pkg::CONFIG_OFFSET;
  localparam logic [7:0] STAT = i2c_ctl_pkg::STATUS_OFFSET;
  localparam int Q = int'(i2c_ctl_pkg::QUARTER_CYC);
  logic clk = 1'b0, rstn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00, pdata = 8'h00, got, tb;
  logic [31:0] pwdata = 32'h0, rd, rnd = 32'hbbef, prdata;
  logic [31:0] mreg [8] = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3};
  logic pready, pslverr, sda_oe_n, scl_oe_n, smb, irq, p_sda, p_scl, sda_w, scl_w, ack, last_bit;
  logic b_sda = 1'b0, b_scl = 1'b0, send = 1'b0, seen_start = 1'b0, seen_stop = 1'b0;
  logic [15:0] stretch = 16'h0;
  logic [7:0] exp_q [$];
  int n_mismatch = 0, check_count = 0, cyc;
  // Pull-ups: a released line reads high
  assign sda_w = sda_oe_n & !b_sda & !p_sda;
  assign scl_w = scl_oe_n & !b_scl & !p_scl;
  always @(posedge scl_w) last_bit <= sda_w;
  always @(negedge sda_w) if (scl_w) seen_start <= 1'b1;
  always @(posedge sda_w) if (scl_w) seen_stop <= 1'b1;
  i2c_control_low_bits u_i2c_control_low_bits (.SYS_CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SDA_I(sda_w), .SDA_O(),
    .SDA_OE_N_O(sda_oe_n), .SCL_I(scl_w), .SCL_O(), .SCL_OE_N_O(scl_oe_n),
    .SMBUS_LEVEL_O(smb), .IRQ_O(irq));
  i2c_peer u_i2c_peer (.clk_i(clk), .scl_i(scl_w), .send_i(send), .data_i(pdata),
    .stretch_i(stretch), .sda_pull_o(p_sda), .scl_pull_o(p_scl));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input int b);
    longint t0;
    int n;
    t0 = $time;
    n = 0;
    apb(1'b1, CTRL, mreg[0] | (32'h1 << b));
    do begin
      apb(1'b0, CTRL, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 4000);
    cyc = int'(($time - t0) / 8);
  endtask
  // Link side at 125 ns per bit; waits out any clock hold by the target
  task automatic lk_bit(input logic b, output logic s);
    b_sda = !b;
    #62.5 b_scl = 1'b0;
    wait (scl_w === 1'b1);
    #62.5 s = sda_w;
    b_scl = 1'b1;
  endtask
  task automatic lk_byte(input logic [7:0] b, input logic a_in, output logic [7:0] g,
    output logic a);
    for (int i = 7; i >= 0; i--) lk_bit(b[i], g[i]);
    lk_bit(a_in, a);
  endtask
  task automatic lk_start();
    b_sda = 1'b1;
    #62.5 b_scl = 1'b1;
  endtask
  task automatic lk_stop();
    b_sda = 1'b1;
    #62.5 b_scl = 1'b0;
    wait (scl_w === 1'b1);
    #62.5 b_sda = 1'b0;
    #125;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (mreg[i]) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset value", mreg[i], rd)
    end
    `CHK("irq idle", 1'b0, irq)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      mreg[0] = rnd & 32'h1e0;
      apb(1'b1, CTRL, mreg[0]);
      apb(1'b0, CTRL, 32'h0);
      `CHK("control", mreg[0], rd)
      `CHK("smbus level", mreg[0][8], smb)
    end
    mreg[0] = 32'h0;
    apb(1'b1, CFG, 32'h1);
    for (int k = 0; k < 2; k++) begin
      seen_start = 1'b0;
      go(k);
      `CHK("start seen", 1'b1, seen_start)
      `CHK("start time", 1'b1, cyc >= (2 + k) * Q && cyc <= (4 + k) * Q + 60)
      rnd = lfsr(rnd);
      pdata = rnd[7:0];
      exp_q.push_back(rnd[7:0]);
      stretch = k ? 16'd0 : 16'd1000;
      send = 1'b1;
      go(i2c_ctl_pkg::CTL_RECEIVE);
      send = 1'b0;
      `CHK("receive cleared", 1'b0, rd[3])
      `CHK("receive time", 1'b1, cyc >= 31 * Q)
      apb(1'b0, i2c_ctl_pkg::RXDATA_OFFSET, 32'h0);
      `CHK("rx byte", {24'h0, exp_q.pop_front()}, rd)
      mreg[0] = (k == 0) ? 32'h20 : 32'h0;
      go(i2c_ctl_pkg::CTL_ACKGO);
      `CHK("ack bit", mreg[0][5], last_bit)
    end
    seen_stop = 1'b0;
    go(i2c_ctl_pkg::CTL_STOP);
    `CHK("stop seen", 1'b1, seen_stop)
    `CHK("stop time", 1'b1, cyc <= 4 * Q + 60)
    // Controller send with nobody answering: done and NACK both flag
    apb(1'b1, i2c_ctl_pkg::TXDATA_OFFSET, {24'h0, rnd[15:8]});
    repeat (40 * Q) @(posedge clk);
    apb(1'b0, STAT, 32'h0);
    `CHK("status", 32'hf, rd & 32'hf)
    apb(1'b1, i2c_ctl_pkg::IRQ_EN_OFFSET, 32'h1);
    @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, i2c_ctl_pkg::IRQ_EN_OFFSET, 32'h0);
    @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, i2c_ctl_pkg::CLEAR_OFFSET, 32'h7f);
    apb(1'b0, STAT, 32'h0);
    `CHK("status cleared", 32'h0, rd)
    apb(1'b0, i2c_ctl_pkg::CLEAR_OFFSET, 32'h0);
    `CHK("clear reads zero", 32'h0, rd)
    apb(1'b1, CFG, 32'h3a07);
    apb(1'b1, CTRL, 32'hc0);
    lk_start();
    lk_byte(8'h00, 1'b1, got, ack);
    `CHK("general call ack", 1'b0, ack)
    apb(1'b0, STAT, 32'h0);
    `CHK("general call flag", 1'b1, rd[i2c_ctl_pkg::EV_GEN_CALL])
    rnd = lfsr(rnd);
    tb = rnd[7:0];
    // Target holds the clock after the eighth bit, so the ack clock waits
    for (int i = 7; i >= 0; i--) lk_bit(tb[i], got[i]);
    repeat (8) @(posedge clk);
    apb(1'b0, CFG, 32'h0);
    `CHK("release cleared", 32'h0, rd & 32'h4)
    `CHK("clock held", 1'b0, scl_oe_n)
    apb(1'b0, i2c_ctl_pkg::RXDATA_OFFSET, 32'h0);
    `CHK("target rx", {24'h0, tb}, rd)
    apb(1'b1, CFG, 32'h3a07);
    repeat (2) @(posedge clk);
    `CHK("clock freed", 1'b1, scl_oe_n)
    lk_bit(1'b1, ack);
    `CHK("data ack", 1'b0, ack)
    lk_stop();
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, CFG, k ? 32'h3a0f : 32'h3a07);
      apb(1'b1, CTRL, k ? 32'h20 : 32'h0);
      lk_start();
      lk_byte(k ? 8'h74 : 8'h00, 1'b1, got, ack);
      `CHK("refused ack", 1'b1, ack)
      lk_stop();
    end
    apb(1'b1, CFG, 32'h3a07);
    apb(1'b1, CTRL, 32'h0);
    apb(1'b1, i2c_ctl_pkg::TXDATA_OFFSET, {24'h0, tb});
    lk_start();
    lk_byte(8'h75, 1'b1, got, ack);
    `CHK("read ack", 1'b0, ack)
    repeat (8) @(posedge clk);
    apb(1'b0, CFG, 32'h0);
    `CHK("release at transmit", 32'h0, rd & 32'h4)
    lk_byte(8'hff, 1'b1, got, ack);
    `CHK("target tx", tb, got)
    lk_stop();
    conclude();
  end
  // Sized for about 75k cycles; the full sequence needs about 45k
  initial begin
    #600000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
